// file: design/rae_cfg.svh
/*
  constants for the record acquisition engine: register offsets, field
  positions, reset values and sizes.
  assumes: included by bare name from the package and the engine module.
*/
`ifndef RAE_CFG_SVH
`define RAE_CFG_SVH

// -----------------------------------------------------------------
// register map (word addresses on the plain register port)
// -----------------------------------------------------------------
`define RAE_ADDR_CTRL    4'h0
`define RAE_ADDR_CMD     4'h1
`define RAE_ADDR_MASK    4'h2
`define RAE_ADDR_RECLEN  4'h3
`define RAE_ADDR_SKIP    4'h4
`define RAE_ADDR_STATUS  4'h5
`define RAE_ADDR_RECCNT  4'h6
`define RAE_ADDR_AVAIL   4'h7
`define RAE_ADDR_LEVEL   4'h8
`define RAE_ADDR_USERID  4'h9

// ctrl fields
`define RAE_CTRL_MODE_LSB  0
`define RAE_CTRL_HDR_BIT   2
`define RAE_CTRL_XFER_BIT  3
// cmd fields (write-one pulses)
`define RAE_CMD_START_BIT  0
`define RAE_CMD_STOP_BIT   1
`define RAE_CMD_REQ_BIT    2

// reset values
`define RAE_CTRL_RST    32'h0000_0004
`define RAE_MASK_RST    4'hF
`define RAE_RECLEN_RST  16'h0010
`define RAE_SKIP_RST    8'h00

// sizes
`define RAE_NCH         4
`define RAE_HDR_WORDS   4'hA
`define RAE_FIFO_AW     10
`define RAE_FIFO_DEPTH  1024
`endif

// file: design/rae_pkg.sv
/*
  types for the record acquisition engine.
  assumes: nothing beyond the config header.
*/
package rae_pkg;
  `include "rae_cfg.svh"

  // -----------------------------------------------------------------
  // modes and states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    RAE_MODE_CONT = 2'b00,
    RAE_MODE_TRIG = 2'b01,
    RAE_MODE_MULT = 2'b10
  } rae_mode_t;

  typedef enum logic [1:0] {
    RAE_ST_IDLE = 2'b00,
    RAE_ST_ARM  = 2'b01,
    RAE_ST_HDR  = 2'b10,
    RAE_ST_DATA = 2'b11
  } rae_state_t;

  // one fifo word: data plus marker bits
  typedef struct packed {
    logic        is_hdr;
    logic        rec_end;
    logic [31:0] data;
  } rae_word_t;
endpackage

// file: design/rae_engine.sv
/*
  record acquisition engine: channel mask, record framing in three modes,
  fixed-size header, on-chip FIFO standing in for the acquisition memory,
  and a DMA-side output port with valid/ready.
  assumes: samples arrive one per channel-slot with a valid strobe; the
  trigger is a one-cycle pulse from outside; the DMA side honours ready.
*/
`timescale 1ns/10ps
`include "rae_cfg.svh"
module rae_engine (
  input  wire logic        i_clk,        // 25 MHz clock
  input  wire logic        i_reset_n,    // async reset, active low
  input  wire logic [3:0]  i_addr,       // register word address
  input  wire logic [31:0] i_wdata,      // register write data
  input  wire logic        i_wr,         // write strobe
  input  wire logic        i_rd,         // read strobe
  output logic      [31:0] o_rdata,      // read data, cycle after i_rd
  input  wire logic        i_smp_valid,  // sample present
  input  wire logic [1:0]  i_smp_ch,     // sample channel
  input  wire logic [15:0] i_smp_data,   // sample value
  input  wire logic        i_smp_ovr,    // sample over/under range
  input  wire logic        i_trig,       // trigger pulse
  input  wire logic [63:0] i_tstamp,     // timestamp counter
  output logic             o_dma_valid,  // output word valid
  output logic      [31:0] o_dma_data,   // output word
  output logic             o_dma_hdr,    // word belongs to header
  output logic             o_dma_last,   // last word of record
  input  wire logic        i_dma_ready,  // DMA accepts word
  output logic             o_busy        // acquisition running
);
  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [31:0]               ctrl_r, ctrl_nxt;
  logic [3:0]                mask_r, mask_nxt;
  logic [15:0]               reclen_r, reclen_nxt;
  logic [7:0]                skip_r, skip_nxt;
  logic [7:0]                userid_r, userid_nxt;
  logic [31:0]               rdata_r, rdata_nxt;
  rae_pkg::rae_mode_t        mode;
  logic                      hdr_en;
  logic                      xfer_sched;
  logic                      cmd_start, cmd_stop, cmd_req;

  assign mode       = rae_pkg::rae_mode_t'(ctrl_r[`RAE_CTRL_MODE_LSB +: 2]);
  assign xfer_sched = ctrl_r[`RAE_CTRL_XFER_BIT];
  // triggered streaming always carries headers, whatever the raw bit says
  assign hdr_en = ctrl_r[`RAE_CTRL_HDR_BIT] | (mode == rae_pkg::RAE_MODE_TRIG);
  assign cmd_start = i_wr & (i_addr == `RAE_ADDR_CMD) & i_wdata[`RAE_CMD_START_BIT];
  assign cmd_stop  = i_wr & (i_addr == `RAE_ADDR_CMD) & i_wdata[`RAE_CMD_STOP_BIT];
  assign cmd_req   = i_wr & (i_addr == `RAE_ADDR_CMD) & i_wdata[`RAE_CMD_REQ_BIT];

  // -----------------------------------------------------------------
  // acquisition state
  // -----------------------------------------------------------------
  rae_pkg::rae_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0]  skc_r, skc_nxt;
  logic [3:0]  hw_r, hw_nxt;
  logic [31:0] recno_r, recno_nxt;
  logic [63:0] ts_r, ts_nxt;
  logic        stop_r, stop_nxt;
  logic        ovr_r, ovr_nxt;
  logic [3:0]  lost_r, lost_nxt;
  logic [2:0]  fillmax_r, fillmax_nxt;
  logic [15:0] avail_r, avail_nxt;
  logic [15:0] grant_r, grant_nxt;

  // fifo
  rae_pkg::rae_word_t        mem [0:`RAE_FIFO_DEPTH-1];
  logic [`RAE_FIFO_AW:0]     wp_r, rp_r;
  logic [`RAE_FIFO_AW:0]     level;
  logic                      full, empty;
  rae_pkg::rae_word_t        wword;
  logic                      push, take;
  logic                      want;
  logic [2:0]                fill8;

  assign level = wp_r - rp_r;
  assign full  = level[`RAE_FIFO_AW];
  assign empty = (level == '0);
  assign fill8 = level[`RAE_FIFO_AW-1 -: 3] | {3{full}};

  // sample kept if its channel is selected and skip slot reached
  logic smp_keep;
  assign smp_keep = i_smp_valid & mask_r[i_smp_ch] & (skc_r == 8'h00);

  // header word mux; status byte, user id and channel mask in word 0
  logic [31:0] hword;
  always_comb begin
    case (hw_r)
      4'h0:    hword = {ovr_r, fillmax_r, lost_r, userid_r, 4'h0, mask_r, 8'h00};
      4'h1:    hword = recno_r;
      4'h2:    hword = ts_r[31:0];
      4'h3:    hword = ts_r[63:32];
      4'h4:    hword = {16'h0000, reclen_r};
      default: hword = 32'h0000_0000; // padding keeps header length fixed
    endcase
  end

  // state machine: next values
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    skc_nxt     = skc_r;
    hw_nxt      = hw_r;
    recno_nxt   = recno_r;
    ts_nxt      = ts_r;
    stop_nxt    = stop_r | cmd_stop;
    ovr_nxt     = ovr_r;
    lost_nxt    = lost_r;
    fillmax_nxt = (fill8 > fillmax_r) ? fill8 : fillmax_r;
    want        = 1'b0;
    wword       = '0;
    case (st_r)
      rae_pkg::RAE_ST_IDLE: begin
        stop_nxt = 1'b0;
        if (cmd_start) begin
          st_nxt = rae_pkg::RAE_ST_ARM;
        end
      end
      rae_pkg::RAE_ST_ARM: begin
        // continuous mode may begin by software start too
        if (stop_r) begin
          st_nxt = rae_pkg::RAE_ST_IDLE;
        end else if (i_trig | (mode == rae_pkg::RAE_MODE_CONT & cmd_start)) begin
          ts_nxt      = i_tstamp;
          cnt_nxt     = 16'h0000;
          skc_nxt     = 8'h00;
          hw_nxt      = 4'h0;
          ovr_nxt     = 1'b0;
          lost_nxt    = 4'h0;
          fillmax_nxt = fill8;
          st_nxt      = hdr_en ? rae_pkg::RAE_ST_HDR : rae_pkg::RAE_ST_DATA;
        end
      end
      rae_pkg::RAE_ST_HDR: begin
        // the header goes first; status reflects state at record start
        want  = 1'b1;
        wword = '{is_hdr: 1'b1, rec_end: 1'b0, data: hword};
        if (full) begin
          lost_nxt[1] = 1'b1;
        end
        if (hw_r == `RAE_HDR_WORDS - 4'h1) begin
          st_nxt = rae_pkg::RAE_ST_DATA;
        end else begin
          hw_nxt = hw_r + 4'h1;
        end
      end
      rae_pkg::RAE_ST_DATA: begin
        if (i_smp_valid & mask_r[i_smp_ch]) begin
          skc_nxt = (skc_r >= skip_r) ? 8'h00 : skc_r + 8'h01;
        end
        if (smp_keep) begin
          want    = 1'b1;
          cnt_nxt = cnt_r + 16'h0001;
          ovr_nxt = ovr_r | i_smp_ovr;
          wword   = '{is_hdr: 1'b0, rec_end: 1'b0, data: {14'h0000, i_smp_ch, i_smp_data}};
          if (full) begin
            lost_nxt[2] = 1'b1;
          end
          // continuous mode runs until stop; others close at the length
          if ((mode != rae_pkg::RAE_MODE_CONT & cnt_r == reclen_r - 16'h0001) |
              (mode == rae_pkg::RAE_MODE_CONT & stop_r)) begin
            wword.rec_end = 1'b1;
            recno_nxt     = recno_r + 32'h0000_0001;
            st_nxt        = (stop_r | cmd_stop) ? rae_pkg::RAE_ST_IDLE
                                                : rae_pkg::RAE_ST_ARM;
          end
        end
      end
      default: st_nxt = rae_pkg::RAE_ST_IDLE;
    endcase
  end

  // dropped when full: acquisition never waits for the host
  assign push = want & ~full;

  // -----------------------------------------------------------------
  // readout gating
  // -----------------------------------------------------------------
  // streaming pushes whenever data exists; scheduled waits for grants.
  // multi-record counts only complete records as available.
  rae_pkg::rae_word_t rword;
  logic               rec_done;
  logic               gate;
  assign rword    = mem[rp_r[`RAE_FIFO_AW-1:0]];
  assign rec_done = push & wword.rec_end;
  always_comb begin
    if (mode == rae_pkg::RAE_MODE_MULT) begin
      gate = (avail_r != 16'h0000) & (grant_r != 16'h0000);
    end else if (xfer_sched) begin
      gate = (grant_r != 16'h0000);
    end else begin
      gate = 1'b1;
    end
  end
  assign take        = ~empty & gate & i_dma_ready;
  assign o_dma_valid = ~empty & gate;
  assign o_dma_data  = rword.data;
  assign o_dma_hdr   = rword.is_hdr;
  assign o_dma_last  = rword.rec_end;
  assign o_busy      = (st_r != rae_pkg::RAE_ST_IDLE);

  // record accounting for host requests
  always_comb begin
    avail_nxt = avail_r + {15'h0000, rec_done} - {15'h0000, take & rword.rec_end};
    grant_nxt = grant_r + {15'h0000, cmd_req} - {15'h0000, take & rword.rec_end};
  end

  // -----------------------------------------------------------------
  // register port
  // -----------------------------------------------------------------
  always_comb begin
    ctrl_nxt   = ctrl_r;
    mask_nxt   = mask_r;
    reclen_nxt = reclen_r;
    skip_nxt   = skip_r;
    userid_nxt = userid_r;
    // configuration is frozen while a run is active
    if (i_wr & st_r == rae_pkg::RAE_ST_IDLE) begin
      case (i_addr)
        `RAE_ADDR_CTRL: begin
          // mode 3 is not a mode; keep the old one
          ctrl_nxt = (i_wdata[1:0] == 2'b11) ? ctrl_r : {28'h0, i_wdata[3:0]};
        end
        `RAE_ADDR_MASK:   mask_nxt   = i_wdata[3:0];
        `RAE_ADDR_RECLEN: reclen_nxt = (i_wdata[15:0] == 16'h0) ? 16'h0001 : i_wdata[15:0];
        `RAE_ADDR_SKIP:   skip_nxt   = i_wdata[7:0];
        `RAE_ADDR_USERID: userid_nxt = i_wdata[7:0];
        default: ;
      endcase
    end
    rdata_nxt = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `RAE_ADDR_CTRL:   rdata_nxt = ctrl_r;
        `RAE_ADDR_MASK:   rdata_nxt = {28'h0, mask_r};
        `RAE_ADDR_RECLEN: rdata_nxt = {16'h0, reclen_r};
        `RAE_ADDR_SKIP:   rdata_nxt = {24'h0, skip_r};
        `RAE_ADDR_STATUS: rdata_nxt = {24'h0, ovr_r, fill8, lost_r} | {o_busy, 31'h0};
        `RAE_ADDR_RECCNT: rdata_nxt = recno_r;
        `RAE_ADDR_AVAIL:  rdata_nxt = {grant_r, avail_r};
        `RAE_ADDR_LEVEL:  rdata_nxt = {21'h0, level};
        `RAE_ADDR_USERID: rdata_nxt = {24'h0, userid_r};
        default:          rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  assign o_rdata = rdata_r;

  // -----------------------------------------------------------------
  // flip-flops
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_r    <= `RAE_CTRL_RST;
      mask_r    <= `RAE_MASK_RST;
      reclen_r  <= `RAE_RECLEN_RST;
      skip_r    <= `RAE_SKIP_RST;
      userid_r  <= 8'h00;
      rdata_r   <= 32'h0000_0000;
      st_r      <= rae_pkg::RAE_ST_IDLE;
      cnt_r     <= 16'h0000;
      skc_r     <= 8'h00;
      hw_r      <= 4'h0;
      recno_r   <= 32'h0000_0000;
      ts_r      <= 64'h0;
      stop_r    <= 1'b0;
      ovr_r     <= 1'b0;
      lost_r    <= 4'h0;
      fillmax_r <= 3'h0;
      avail_r   <= 16'h0000;
      grant_r   <= 16'h0000;
      wp_r      <= '0;
      rp_r      <= '0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      mask_r    <= mask_nxt;
      reclen_r  <= reclen_nxt;
      skip_r    <= skip_nxt;
      userid_r  <= userid_nxt;
      rdata_r   <= rdata_nxt;
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      skc_r     <= skc_nxt;
      hw_r      <= hw_nxt;
      recno_r   <= recno_nxt;
      ts_r      <= ts_nxt;
      stop_r    <= stop_nxt;
      ovr_r     <= ovr_nxt;
      lost_r    <= lost_nxt;
      fillmax_r <= fillmax_nxt;
      avail_r   <= avail_nxt;
      grant_r   <= grant_nxt;
      wp_r      <= wp_r + {{`RAE_FIFO_AW{1'b0}}, push};
      rp_r      <= rp_r + {{`RAE_FIFO_AW{1'b0}}, take};
    end
  end

  // memory array has no reset; write only
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r[`RAE_FIFO_AW-1:0]] <= wword;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_mask_drop;
    @(posedge i_clk) disable iff (!i_reset_n)
      (st_r == rae_pkg::RAE_ST_DATA & i_smp_valid & ~mask_r[i_smp_ch]) |-> ~want;
  endproperty
  a_mask_drop: assert property (p_mask_drop) else $error("unselected channel written");

  property p_hdr_len;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(st_r == rae_pkg::RAE_ST_HDR) |-> ##9 (st_r == rae_pkg::RAE_ST_HDR && hw_r == 4'h9)
      ##1 (st_r == rae_pkg::RAE_ST_DATA);
  endproperty
  a_hdr_len: assert property (p_hdr_len) else $error("header length not fixed");

  property p_trig_hdr;
    @(posedge i_clk) disable iff (!i_reset_n)
      (st_r == rae_pkg::RAE_ST_ARM & i_trig & ~stop_r & mode == rae_pkg::RAE_MODE_TRIG)
      |=> (st_r == rae_pkg::RAE_ST_HDR);
  endproperty
  a_trig_hdr: assert property (p_trig_hdr) else $error("triggered record lacks header");

  property p_no_stall;
    @(posedge i_clk) disable iff (!i_reset_n)
      (want & full) |-> ~push;
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("write into full buffer");

  property p_lost_flag;
    @(posedge i_clk) disable iff (!i_reset_n)
      (st_r == rae_pkg::RAE_ST_DATA & want & full) |=> lost_r[2];
  endproperty
  a_lost_flag: assert property (p_lost_flag) else $error("loss not flagged");

  property p_sched;
    @(posedge i_clk) disable iff (!i_reset_n)
      (xfer_sched & grant_r == 16'h0000) |-> ~o_dma_valid;
  endproperty
  a_sched: assert property (p_sched) else $error("unrequested transfer");

  property p_mult;
    @(posedge i_clk) disable iff (!i_reset_n)
      (mode == rae_pkg::RAE_MODE_MULT & avail_r == 16'h0000) |-> ~o_dma_valid;
  endproperty
  a_mult: assert property (p_mult) else $error("incomplete record read out");

  property p_recno;
    @(posedge i_clk) disable iff (!i_reset_n)
      rec_done |=> (recno_r == $past(recno_r) + 32'h0000_0001);
  endproperty
  a_recno: assert property (p_recno) else $error("record count not advanced");

  property p_stop;
    @(posedge i_clk) disable iff (!i_reset_n)
      (rec_done & stop_r) |=> (st_r == rae_pkg::RAE_ST_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured");

  c_overflow: cover property (@(posedge i_clk) disable iff (!i_reset_n) want & full);
  c_rec_done: cover property (@(posedge i_clk) disable iff (!i_reset_n) rec_done);
  c_dma_last: cover property (@(posedge i_clk) disable iff (!i_reset_n) take & o_dma_last);
endmodule

// file: test/rae_host_model.sv
/*
  host-side dma consumer: takes words from the engine and keeps them in order.
  assumes: shares the engine clock and reset; the bench sets stall and slow.
*/
`timescale 1ns/10ps
module rae_host_model (
  input  wire logic        i_clk,      // engine clock
  input  wire logic        i_reset_n,  // async reset, active low
  input  wire logic        i_valid,    // word offered
  input  wire logic [31:0] i_data,     // word data
  input  wire logic        i_hdr,      // header word
  input  wire logic        i_last,     // last word of record
  input  wire logic        i_stall,    // refuse every word
  input  wire logic        i_slow,     // accept every other cycle
  output logic             o_ready     // word accepted
);
  rae_pkg::rae_word_t mem [0:2047];
  logic [11:0]        count_r;
  logic               phase_r;

  // -----------------------------------------------------------------
  // acceptance
  // -----------------------------------------------------------------
  // a stalled host is the late consumer that lets the buffer overflow
  assign o_ready = !i_stall && !(i_slow && phase_r);

  // store each accepted word; the bench reads them back in order
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_r <= 12'h000;
      phase_r <= 1'b0;
    end else begin
      phase_r <= !phase_r;
      if (i_valid && o_ready) begin
        mem[count_r] <= '{is_hdr: i_hdr, rec_end: i_last, data: i_data};
        count_r      <= count_r + 12'h001;
      end
    end
  end
endmodule

// file: test/rae_engine_tb.sv
/*
  self-checking bench for the engine: register port tasks, sample feed,
  and a host consumer model on the dma side.
  assumes: engine and host model compiled first; one 25 MHz clock.
*/
`timescale 1ns/10ps
`include "rae_cfg.svh"
module rae_engine_tb;
  localparam logic [63:0] TS = 64'h0123_4567_89AB_CDEF;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic        i_smp_valid = 1'b0;
  logic [1:0]  i_smp_ch = 2'h0;
  logic [15:0] i_smp_data = 16'h0;
  logic        i_smp_ovr = 1'b0;
  logic        i_trig = 1'b0;
  logic [63:0] i_tstamp = 64'h0;
  logic        o_dma_valid, o_dma_hdr, o_dma_last, i_dma_ready;
  logic [31:0] o_dma_data;
  logic        o_busy;
  logic        stall = 1'b0;
  logic        slow = 1'b0;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;

  rae_engine rae_engine_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_smp_valid(i_smp_valid), .i_smp_ch(i_smp_ch), .i_smp_data(i_smp_data),
    .i_smp_ovr(i_smp_ovr), .i_trig(i_trig), .i_tstamp(i_tstamp), .o_dma_valid(o_dma_valid),
    .o_dma_data(o_dma_data), .o_dma_hdr(o_dma_hdr), .o_dma_last(o_dma_last),
    .i_dma_ready(i_dma_ready), .o_busy(o_busy));
  rae_host_model rae_host_model_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_valid(o_dma_valid), .i_data(o_dma_data), .i_hdr(o_dma_hdr), .i_last(o_dma_last),
    .i_stall(stall), .i_slow(slow), .o_ready(i_dma_ready));

  // -----------------------------------------------------------------
  // clock, run limit and verdict
  // -----------------------------------------------------------------
  initial begin
    forever #20 i_clk = !i_clk;
  end
  // a hang is cut short well above the longest drain in the run
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // -----------------------------------------------------------------
  // register port and sample tasks
  // -----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rst();
    i_reset_n <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
  endtask
  // channels run 0..3 round robin; tat places a trigger on that sample
  task automatic feed(input int n, input logic [15:0] base, input int tat);
    for (int j = 0; j < n; j++) begin
      @(posedge i_clk);
      i_smp_valid <= 1'b1;
      i_smp_ch    <= j[1:0];
      i_smp_data  <= base + j[15:0];
      i_trig      <= (j == tat);
    end
    @(posedge i_clk);
    i_smp_valid <= 1'b0;
    i_trig      <= 1'b0;
  endtask
  task automatic pulse(input logic [63:0] t);
    @(posedge i_clk);
    i_trig   <= 1'b1;
    i_tstamp <= t;
    @(posedge i_clk);
    i_trig   <= 1'b0;
    repeat (14) @(posedge i_clk);
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial begin
    logic [31:0]        d;
    rae_pkg::rae_word_t w;
    int                 j;
    rst();
    rd(`RAE_ADDR_CTRL, d);   check("ctrl_rst", d, 32'h0000_0004);
    rd(`RAE_ADDR_MASK, d);   check("mask_rst", d, 32'h0000_000F);
    rd(`RAE_ADDR_RECLEN, d); check("len_rst", d, 32'h0000_0010);
    rd(4'hF, d);             check("unmapped", d, 32'h0);
    // triggered, header bit off, channels 0 and 2, slow host, two records
    slow <= 1'b1;
    wr(`RAE_ADDR_CTRL, 32'h0000_0001);
    // mode 3 is refused, the triggered mode must survive it
    wr(`RAE_ADDR_CTRL, 32'h0000_0003);
    rd(`RAE_ADDR_CTRL, d);   check("mode3", d, 32'h0000_0001);
    wr(`RAE_ADDR_MASK, 32'h0000_0005);
    wr(`RAE_ADDR_RECLEN, 32'h0000_0004);
    wr(`RAE_ADDR_CMD, 32'h0000_0001);
    for (int r = 0; r < 2; r++) begin
      pulse(TS + r);
      check("early_out", 32'(rae_host_model_inst.count_r > r * 14), 32'h1);
      feed(8, 16'h1000 + 16'(r * 256), (r == 0) ? 4 : -1);
    end
    repeat (60) @(posedge i_clk);
    check("trig_cnt", 32'(rae_host_model_inst.count_r), 32'd28);
    for (int i = 0; i < 28; i++) begin
      w = rae_host_model_inst.mem[i];
      j = 2 * (i % 14 - 10);
      check("hdr_flag", 32'(w.is_hdr), 32'(i % 14 < 10));
      check("last", 32'(w.rec_end), 32'(i % 14 == 13));
      if (i % 14 == 0) begin
        check("w0_mask", 32'(w.data[11:8]), 32'h5);
        check("w0_stat", 32'(w.data[31:24]), 32'h0);
      end else if (i % 14 == 1) check("rec_no", w.data, 32'(i / 14));
      else if (i % 14 == 2) check("ts_lo", w.data, TS[31:0] + i / 14);
      else if (i % 14 == 3) check("ts_hi", w.data, TS[63:32]);
      else if (i % 14 == 4) check("rec_len", w.data, 32'h4);
      else if (i % 14 < 10) check("hdr_zero", w.data, 32'h0);
      else check("data", 32'(w.data[17:0]),
        32'({j[1:0], 16'h1000 + 16'((i / 14) * 256 + j)}));
    end
    rd(`RAE_ADDR_RECCNT, d); check("reccnt", d, 32'h2);
    wr(`RAE_ADDR_CMD, 32'h0000_0002);
    rd(`RAE_ADDR_STATUS, d); check("idle", 32'(d[31]), 32'h0);
    // multi-record with header: request first, data only when complete
    rst();
    slow <= 1'b0;
    wr(`RAE_ADDR_CTRL, 32'h0000_0006);
    wr(`RAE_ADDR_RECLEN, 32'h0000_0004);
    wr(`RAE_ADDR_CMD, 32'h0000_0001);
    wr(`RAE_ADDR_CMD, 32'h0000_0004);
    pulse(TS);
    feed(3, 16'h2000, -1);
    check("held", 32'(rae_host_model_inst.count_r), 32'h0);
    feed(1, 16'h2003, -1);
    repeat (30) @(posedge i_clk);
    check("one_rec", 32'(rae_host_model_inst.count_r), 32'd14);
    pulse(TS);
    feed(4, 16'h2100, -1);
    repeat (30) @(posedge i_clk);
    check("no_req", 32'(rae_host_model_inst.count_r), 32'd14);
    rd(`RAE_ADDR_AVAIL, d); check("avail", 32'(d[15:0]), 32'h1);
    wr(`RAE_ADDR_CMD, 32'h0000_0004);
    repeat (30) @(posedge i_clk);
    check("two_rec", 32'(rae_host_model_inst.count_r), 32'd28);
    // continuous, raw, scheduled, keep one of two samples, then stop
    rst();
    wr(`RAE_ADDR_CTRL, 32'h0000_0008);
    wr(`RAE_ADDR_SKIP, 32'h0000_0001);
    wr(`RAE_ADDR_CMD, 32'h0000_0001);
    wr(`RAE_ADDR_CMD, 32'h0000_0001);
    feed(8, 16'h3000, -1);
    repeat (8) @(posedge i_clk);
    check("sched_hold", 32'(rae_host_model_inst.count_r), 32'h0);
    wr(`RAE_ADDR_CMD, 32'h0000_0004);
    repeat (8) @(posedge i_clk);
    check("kept", 32'(rae_host_model_inst.count_r), 32'h4);
    check("raw", 32'(rae_host_model_inst.mem[0].is_hdr), 32'h0);
    check("step", 32'(rae_host_model_inst.mem[1].data[15:0] -
      rae_host_model_inst.mem[0].data[15:0]), 32'h2);
    wr(`RAE_ADDR_CMD, 32'h0000_0002);
    feed(4, 16'h3100, -1);
    rd(`RAE_ADDR_STATUS, d); check("stopped", 32'(d[31]), 32'h0);
    // overflow with a stalled host, then drain
    rst();
    stall <= 1'b1;
    i_smp_ovr <= 1'b1;
    wr(`RAE_ADDR_CTRL, 32'h0000_0000);
    wr(`RAE_ADDR_CMD, 32'h0000_0001);
    wr(`RAE_ADDR_CMD, 32'h0000_0001);
    feed(1100, 16'h4000, -1);
    rd(`RAE_ADDR_LEVEL, d);  check("level", d, 32'd1024);
    rd(`RAE_ADDR_STATUS, d); check("lost", 32'(d[2]), 32'h1);
    check("fill", 32'(d[6:4]), 32'h7);
    check("running", 32'(d[31]), 32'h1);
    check("range", 32'(d[7]), 32'h1);
    check("busy", 32'(o_busy), 32'h1);
    stall <= 1'b0;
    repeat (1100) @(posedge i_clk);
    check("drained", 32'(rae_host_model_inst.count_r), 32'd1024);
    close_out();
  end
endmodule
